// ### include/safety_switch_pkg.sv
// Constants, commands and state types for the safety switch output logic
// Operation
// - When ready, each safety output follows its input while actuator is detected.
// - No actuator detected drives both safety outputs low whatever the inputs.
// - Without diagnostics, status output shows actuator presence, ignoring safety inputs.
// - One input falling while the other stays high flags unequal inputs, LED flashes.
// - Fallen input returning high, other still high, flags error and locks partial operation.
// - Lock clears, normal rising accepted, only after both inputs were low together or the unit left ready.
// - Attached diagnostic module enables diagnostic input; otherwise that input is ignored.
// - Attached diagnostic module turns status output into diagnostic data output.
// - Diagnostics restart automatically after every power-up; serial number reveals replacement.
// - Device answers status, teach-in count, serial number and name refresh requests.
// - Low safety outputs represent the safe state.
package safety_switch_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 20;
    localparam int BIT_TIME_NS    = 20000;       // Diagnostic bit time
    localparam int BIT_CYCLES     = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_BIT       = BIT_CYCLES / 2;
    localparam int FLASH_HALF_NS  = 250000000;   // LED flash half period
    localparam int FLASH_CYCLES   = FLASH_HALF_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Diagnostic frames
    // ----------------------------------------------------------------
    localparam int CMD_W          = 8;
    localparam int REPLY_W        = 16;
    localparam int TX_BITS        = REPLY_W + 2; // Start, data, stop
    localparam logic [7:0]  CMD_STATUS    = 8'h01;
    localparam logic [7:0]  CMD_TEACH     = 8'h02;
    localparam logic [7:0]  CMD_SERIAL_LO = 8'h03;
    localparam logic [7:0]  CMD_SERIAL_HI = 8'h04;
    localparam logic [7:0]  CMD_REFRESH   = 8'h05;
    localparam logic [15:0] REPLY_ACK     = 16'h0001;
    localparam logic [15:0] REPLY_BAD     = 16'hffff;

    // ----------------------------------------------------------------
    // State types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
    typedef enum logic [1:0] {PL_OK, PL_UNEQ1, PL_UNEQ2, PL_LOCK} plaus_state_e;

endpackage : safety_switch_pkg

// ### include/plaus_if.sv
// Interface between the output logic and the input plausibility monitor
`timescale 1ns/1ps
interface plaus_if;
    logic ch1;
    logic ch2;
    logic enable;
    logic unequal;
    logic lock;
    modport monitor (input ch1, input ch2, input enable, output unequal, output lock);
    modport user    (output ch1, output ch2, output enable, input unequal, input lock);
endinterface : plaus_if

// ### logic/input_plausibility.sv
// Plausibility monitor of the two safety inputs with partial-operation lock
`timescale 1ns/1ps
module input_plausibility
    import safety_switch_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    plaus_if.monitor  bus
);

    typedef struct packed {
        plaus_state_e st;
        logic         prev1;
        logic         prev2;
    } mon_s;

    mon_s s_q;
    mon_s s_d;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d       = s_q;
        s_d.prev1 = bus.ch1;
        s_d.prev2 = bus.ch2;
        if (!bus.enable)
        begin
            s_d.st = PL_OK;
        end
        else
        begin
            case (s_q.st)
                PL_OK:
                begin
                    if (s_q.prev1 && s_q.prev2 && !bus.ch1 && bus.ch2)
                        s_d.st = PL_UNEQ1;
                    else if (s_q.prev1 && s_q.prev2 && bus.ch1 && !bus.ch2)
                        s_d.st = PL_UNEQ2;
                end
                PL_UNEQ1:
                begin
                    if (!bus.ch2)
                        s_d.st = bus.ch1 ? PL_UNEQ2 : PL_OK;
                    else if (bus.ch1)
                        s_d.st = PL_LOCK;
                end
                PL_UNEQ2:
                begin
                    if (!bus.ch1)
                        s_d.st = bus.ch2 ? PL_UNEQ1 : PL_OK;
                    else if (bus.ch2)
                        s_d.st = PL_LOCK;
                end
                PL_LOCK:
                begin
                    if (!bus.ch1 && !bus.ch2)
                        s_d.st = PL_OK;
                end
                default:
                begin
                    s_d.st = PL_OK;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // Flags from the state register
    assign bus.unequal = (s_q.st == PL_UNEQ1) || (s_q.st == PL_UNEQ2);
    assign bus.lock    = (s_q.st == PL_LOCK);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_unequal_flag;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (bus.enable && s_q.st == PL_OK && s_q.prev1 && s_q.prev2 && !bus.ch1 && bus.ch2)
            |=> bus.unequal;
    endproperty
    a_unequal_flag: assert property (p_unequal_flag)
        else $error("unequal inputs not flagged");

    property p_lock_set;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (bus.enable && bus.unequal && bus.ch1 && bus.ch2) |=> bus.lock;
    endproperty
    a_lock_set: assert property (p_lock_set)
        else $error("partial-operation lock not entered");

    property p_lock_hold;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (bus.enable && bus.lock && (bus.ch1 || bus.ch2)) |=> bus.lock;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lock released before both inputs were low");

    property p_lock_clear;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (bus.lock && !bus.ch1 && !bus.ch2) |=> !bus.lock;
    endproperty
    a_lock_clear: assert property (p_lock_clear)
        else $error("lock not cleared after both inputs low");

endmodule : input_plausibility

// ### logic/safety_switch_output_logic.sv
// Output decision logic, input indicator and diagnostic responder of the safety switch
`timescale 1ns/1ps
module safety_switch_output_logic
    import safety_switch_pkg::*;
#(
    parameter int FLASH_HALF_CYCLES = FLASH_CYCLES
)
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ready,
    input  wire logic        i_actuator_detected,
    input  wire logic        i_safety_in_ch1,
    input  wire logic        i_safety_in_ch2,
    input  wire logic        i_diag_attached,
    input  wire logic        i_diag_in,
    input  wire logic [7:0]  i_teach_remaining,
    input  wire logic [31:0] i_serial_number,
    output logic             o_safety_out_ch1,
    output logic             o_safety_out_ch2,
    output logic             o_status_diag_out,
    output logic             o_input_led,
    output logic             o_partial_lock,
    output logic             o_name_refresh
);
    import safety_switch_pkg::*;

    localparam int FW = $clog2(FLASH_HALF_CYCLES + 1);
    localparam int BW = $clog2(BIT_CYCLES + 1);

    typedef struct packed {
        logic                 out1;
        logic                 out2;
        logic                 status;
        logic                 led;
        logic                 blink;
        logic [FW-1:0]        flash_cnt;
        rx_state_e            rx_st;
        logic [BW-1:0]        rx_cnt;
        logic [3:0]           rx_bits;
        logic [CMD_W-1:0]     rx_shift;
        logic                 tx_busy;
        logic [BW-1:0]        tx_cnt;
        logic [4:0]           tx_bits;
        logic [TX_BITS-1:0]   tx_shift;
        logic                 refresh;
    } state_s;

    state_s s_q;
    state_s s_d;

    // ----------------------------------------------------------------
    // Plausibility monitor
    // ----------------------------------------------------------------
    plaus_if u_pl ();

    // Monitor runs only while the unit is ready
    assign u_pl.ch1    = i_safety_in_ch1;
    assign u_pl.ch2    = i_safety_in_ch2;
    assign u_pl.enable = i_ready;

    input_plausibility u_mon (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .bus     (u_pl.monitor)
    );

    // ----------------------------------------------------------------
    // Reply lookup
    // ----------------------------------------------------------------
    function automatic logic [REPLY_W-1:0] reply_for(
        input logic [CMD_W-1:0] cmd,
        input logic [7:0]       stat,
        input logic [7:0]       teach,
        input logic [31:0]      serial
    );
        logic [REPLY_W-1:0] r;
        r = REPLY_BAD;
        case (cmd)
            CMD_STATUS:    r = {8'h00, stat};
            CMD_TEACH:     r = {8'h00, teach};
            CMD_SERIAL_LO: r = serial[15:0];
            CMD_SERIAL_HI: r = serial[31:16];
            CMD_REFRESH:   r = REPLY_ACK;
            default:       r = REPLY_BAD;
        endcase
        return r;
    endfunction : reply_for

    logic [7:0] status_word;

    // Live status word reported on request
    assign status_word = {i_ready, u_pl.lock, u_pl.unequal, s_q.out2, s_q.out1,
                          i_safety_in_ch2, i_safety_in_ch1, i_actuator_detected};

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic pass;
        logic rx_done;
        pass    = 1'b0;
        rx_done = 1'b0;
        s_d     = s_q;
        s_d.refresh = 1'b0;

        // Safety outputs: low is safe, inputs passed only with actuator
        pass     = i_ready && i_actuator_detected && !u_pl.lock;
        s_d.out1 = pass && i_safety_in_ch1;
        s_d.out2 = pass && i_safety_in_ch2;

        // Flash timebase for the input indicator
        if (s_q.flash_cnt >= FW'(FLASH_HALF_CYCLES - 1))
        begin
            s_d.flash_cnt = '0;
            s_d.blink     = !s_q.blink;
        end
        else
        begin
            s_d.flash_cnt = s_q.flash_cnt + 1'b1;
        end

        // Input indicator: steady with both high, flashing on fault
        if (!i_ready)
            s_d.led = 1'b0;
        else if (u_pl.unequal || u_pl.lock)
            s_d.led = s_q.blink;
        else
            s_d.led = i_safety_in_ch1 && i_safety_in_ch2;

        // Diagnostic receiver, idle unless a module is attached
        if (!i_diag_attached || !i_ready)
        begin
            s_d.rx_st = RX_IDLE;
            s_d.rx_cnt = '0;
        end
        else
        begin
            case (s_q.rx_st)
                RX_IDLE:
                begin
                    s_d.rx_cnt = '0;
                    if (!i_diag_in)
                        s_d.rx_st = RX_START;
                end
                RX_START:
                begin
                    s_d.rx_cnt = s_q.rx_cnt + 1'b1;
                    if (s_q.rx_cnt == BW'(HALF_BIT - 1))
                    begin
                        s_d.rx_cnt  = '0;
                        s_d.rx_bits = '0;
                        s_d.rx_st   = i_diag_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    s_d.rx_cnt = s_q.rx_cnt + 1'b1;
                    if (s_q.rx_cnt == BW'(BIT_CYCLES - 1))
                    begin
                        s_d.rx_cnt   = '0;
                        s_d.rx_shift = {i_diag_in, s_q.rx_shift[CMD_W-1:1]};
                        s_d.rx_bits  = s_q.rx_bits + 1'b1;
                        if (s_q.rx_bits == 4'h7)
                            s_d.rx_st = RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    s_d.rx_cnt = s_q.rx_cnt + 1'b1;
                    if (s_q.rx_cnt == BW'(BIT_CYCLES - 1))
                    begin
                        s_d.rx_st = RX_IDLE;
                        rx_done   = i_diag_in;
                    end
                end
                default:
                begin
                    s_d.rx_st = RX_IDLE;
                end
            endcase
        end

        // Diagnostic transmitter, least significant bit first
        if (s_q.tx_busy)
        begin
            s_d.tx_cnt = s_q.tx_cnt + 1'b1;
            if (s_q.tx_cnt == BW'(BIT_CYCLES - 1))
            begin
                s_d.tx_cnt   = '0;
                s_d.tx_shift = {1'b1, s_q.tx_shift[TX_BITS-1:1]};
                s_d.tx_bits  = s_q.tx_bits + 1'b1;
                if (s_q.tx_bits == 5'(TX_BITS - 1))
                    s_d.tx_busy = 1'b0;
            end
        end
        else if (rx_done)
        begin
            s_d.tx_busy  = 1'b1;
            s_d.tx_cnt   = '0;
            s_d.tx_bits  = '0;
            s_d.tx_shift = {1'b1, reply_for(s_q.rx_shift, status_word,
                                            i_teach_remaining, i_serial_number), 1'b0};
            s_d.refresh  = (s_q.rx_shift == CMD_REFRESH);
        end
        if (!i_diag_attached || !i_ready)
        begin
            s_d.tx_busy  = 1'b0;
            s_d.tx_shift = '1;
        end

        // Status pin: actuator state, or diagnostic line when attached
        if (!i_ready)
            s_d.status = 1'b0;
        else if (i_diag_attached)
            s_d.status = s_d.tx_busy ? s_d.tx_shift[0] : 1'b1;
        else
            s_d.status = i_actuator_detected;
    end

    // State register; every power-up starts the diagnostic link from idle
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // Outputs straight from the state register; partial lock straight from the monitor's lock flag
    assign o_safety_out_ch1  = s_q.out1;
    assign o_safety_out_ch2  = s_q.out2;
    assign o_status_diag_out = s_q.status;
    assign o_input_led       = s_q.led;
    assign o_partial_lock    = u_pl.lock;
    assign o_name_refresh    = s_q.refresh;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_follow;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ready && i_actuator_detected && !u_pl.lock)
            |=> (o_safety_out_ch1 == $past(i_safety_in_ch1))
             && (o_safety_out_ch2 == $past(i_safety_in_ch2));
    endproperty
    a_follow: assert property (p_follow)
        else $error("safety outputs do not follow inputs");

    property p_no_actuator;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !i_actuator_detected |=> !o_safety_out_ch1 && !o_safety_out_ch2;
    endproperty
    a_no_actuator: assert property (p_no_actuator)
        else $error("safety output high without actuator");

    property p_status_plain;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ready && !i_diag_attached) |=> o_status_diag_out == $past(i_actuator_detected);
    endproperty
    a_status_plain: assert property (p_status_plain)
        else $error("status output does not show actuator");

    property p_diag_ignored;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !i_diag_attached |=> s_q.rx_st == RX_IDLE && !s_q.tx_busy;
    endproperty
    a_diag_ignored: assert property (p_diag_ignored)
        else $error("diagnostic input used without module");

    property p_diag_line;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ready && i_diag_attached && s_q.tx_busy && s_q.tx_cnt == '0)
            |-> o_status_diag_out == s_q.tx_shift[0];
    endproperty
    a_diag_line: assert property (p_diag_line)
        else $error("diagnostic output does not carry frame bit");

    property p_reply_start;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ready && i_diag_attached && !s_q.tx_busy && s_q.rx_st == RX_STOP
         && s_q.rx_cnt == BW'(BIT_CYCLES - 1) && i_diag_in)
            ##1 (i_ready && i_diag_attached) |-> s_q.tx_busy && !o_status_diag_out;
    endproperty
    a_reply_start: assert property (p_reply_start)
        else $error("request not answered with start bit");

    property p_not_ready;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !i_ready |=> !o_safety_out_ch1 && !o_safety_out_ch2 && !o_partial_lock;
    endproperty
    a_not_ready: assert property (p_not_ready)
        else $error("outputs active before readiness");

    property p_lock_safe;
        @(posedge i_mclk) disable iff (!i_rst_n)
        o_partial_lock |=> !o_safety_out_ch1 && !o_safety_out_ch2;
    endproperty
    a_lock_safe: assert property (p_lock_safe)
        else $error("safety output high under lock");

endmodule : safety_switch_output_logic

// ### bench/diag_partner.sv
// Model of the evaluation device and the diagnostic fieldbus module
`timescale 1ns/1ps
module diag_partner
#(
    parameter int BIT_CYC   = 1000,
    parameter int MAX_NODES = 16    // Chain holds at most this many sensors
)
(
    input  wire logic i_mclk,
    input  wire logic i_out_ch1,
    input  wire logic i_out_ch2,
    input  wire logic i_line,
    output logic      o_diag,
    output logic      o_mismatch
);
    // --------------------------------------------------------------
    // Evaluation side: two channels compared for plausibility
    // --------------------------------------------------------------
    assign o_mismatch = i_out_ch1 ^ i_out_ch2;

    // Line idles high; no set-up exchange is needed after power-up
    initial o_diag = 1'b1;

    // --------------------------------------------------------------
    // Request: start bit, command LSB first, stop level left standing
    // --------------------------------------------------------------
    task automatic send(input logic [7:0] cmd);
        o_diag = 1'b0;
        repeat (BIT_CYC) @(negedge i_mclk);
        for (int i = 0; i < 8; i++)
        begin
            o_diag = cmd[i];
            repeat (BIT_CYC) @(negedge i_mclk);
        end
        o_diag = 1'b1;
    endtask : send

    // Reply: bounded wait for start, then sample each bit in its middle
    task automatic recv(output logic [15:0] data, output logic ok);
        int n;
        n = 0;
        data = '0;
        while (i_line !== 1'b0 && n < 3 * BIT_CYC)
        begin
            @(negedge i_mclk);
            n++;
        end
        repeat (BIT_CYC / 2) @(negedge i_mclk);
        ok = (n < 3 * BIT_CYC) && (i_line === 1'b0);
        for (int i = 0; i < 16; i++)
        begin
            repeat (BIT_CYC) @(negedge i_mclk);
            data[i] = i_line;
        end
        repeat (BIT_CYC) @(negedge i_mclk);
        ok = ok && (i_line === 1'b1);
        repeat (BIT_CYC / 2) @(negedge i_mclk);
    endtask : recv
endmodule : diag_partner

// ### bench/test_safety_switch_output_logic.sv
// Self-checking testbench of the safety switch output logic
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module test_safety_switch_output_logic;
    import safety_switch_pkg::*;
    logic        clk, rst_n, rdy, act, c1, c2, att, din, o1, o2, st, led, lk, rf, mm;
    logic [7:0]  teach;
    logic [31:0] serial;
    logic [15:0] rep;
    logic        ok;
    int          mismatches, comparisons, ref_cnt, tg, cnt;
    // Rows: ready, actuator, ch1, ch2, expected out1, out2, status
    localparam logic [6:0] ROWS [9] = '{7'b1111111, 7'b1100001, 7'b1110101, 7'b1100001,
        7'b1101011, 7'b1100001, 7'b1011000, 7'b1000000, 7'b0111000};
    localparam logic [7:0]  CMDS [3] = '{CMD_STATUS, CMD_SERIAL_HI, CMD_REFRESH};
    localparam logic [15:0] REPS [3] = '{16'h009f, 16'h5a3c, REPLY_ACK};

    safety_switch_output_logic #(.FLASH_HALF_CYCLES(4)) DUT (
        .i_mclk(clk), .i_rst_n(rst_n), .i_ready(rdy), .i_actuator_detected(act),
        .i_safety_in_ch1(c1), .i_safety_in_ch2(c2), .i_diag_attached(att),
        .i_diag_in(din), .i_teach_remaining(teach), .i_serial_number(serial),
        .o_safety_out_ch1(o1), .o_safety_out_ch2(o2), .o_status_diag_out(st),
        .o_input_led(led), .o_partial_lock(lk), .o_name_refresh(rf));

    diag_partner #(.BIT_CYC(BIT_CYCLES)) P (.i_mclk(clk), .i_out_ch1(o1), .i_out_ch2(o2),
        .i_line(st),
        .o_diag(din), .o_mismatch(mm));

    // ------------------------------------------------------------------
    // Clock, refresh pulse counter, watchdog
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) if (rf === 1'b1) ref_cnt++;

    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        test_done();
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    // Apply input levels at the falling edge and let n edges pass
    task automatic drive(input logic [3:0] v, input int n);
        {rdy, act, c1, c2} = v;
        repeat (n) @(negedge clk);
    endtask : drive

    // Count input indicator changes over n cycles
    task automatic led_watch(input int n);
        logic prev;
        tg = 0;
        cnt = 0;
        prev = led;
        repeat (n)
        begin
            @(negedge clk);
            if (led !== prev) tg++;
            if (led === 1'b1) cnt++;
            prev = led;
        end
    endtask : led_watch

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {rst_n, rdy, act, c1, c2, att} = 6'b0;
        teach = 8'h2a;
        serial = 32'h5a3c_96e1;
        mismatches = 0;
        comparisons = 0;
        ref_cnt = 0;
        repeat (6) @(negedge clk);
        `CHK("reset_outs", 2'b00, {o1, o2})
        rst_n = 1'b1;
        @(negedge clk);
        foreach (ROWS[i])
        begin
            drive(ROWS[i][6:3], 2);
            `CHK("out_ch1", ROWS[i][2], o1)
            `CHK("out_ch2", ROWS[i][1], o2)
            `CHK("status", ROWS[i][0], st)
            `CHK("eval_mismatch", ROWS[i][2] ^ ROWS[i][1], mm)
        end
        drive(4'b1111, 2);
        led_watch(8);
        `CHK("led_steady", 8, cnt)
        drive(4'b1101, 1);
        `CHK("unequal_outs", 3'b010, {o1, o2, lk})
        led_watch(12);
        `CHK("led_flash", 1'b1, tg >= 2)
        drive(4'b1111, 2);
        `CHK("lock_outs", 3'b001, {o1, o2, lk})
        `CHK("lock_safe", 2'b00, {o1, o2})
        led_watch(12);
        `CHK("lock_flash", 1'b1, tg >= 2)
        drive(4'b1100, 1);
        `CHK("lock_clear", 1'b0, lk)
        drive(4'b1111, 2);
        `CHK("resume", 3'b110, {o1, o2, lk})
        drive(4'b1110, 2);
        drive(4'b1111, 2);
        `CHK("relock", 1'b1, lk)
        // Reset in mid-run while locked: everything drops to the safe state
        rst_n = 1'b0;
        @(negedge clk);
        `CHK("mid_reset", 4'b0000, {o1, o2, lk, led})
        rst_n = 1'b1;
        drive(4'b1111, 2);
        `CHK("after_reset", 3'b110, {o1, o2, lk})
        drive(4'b0111, 2);
        `CHK("unready", 3'b000, {o1, o2, lk})
        drive(4'b1100, 2);
        drive(4'b1111, 2);
        att = 1'b1;
        repeat (2) @(negedge clk);
        `CHK("diag_idle", 1'b1, st)
        foreach (CMDS[i])
        begin
            P.send(CMDS[i]);
            P.recv(rep, ok);
            `CHK("reply_frame", 1'b1, ok)
            `CHK("reply_data", REPS[i], rep)
            `CHK("refresh_count", (i == 2) ? 1 : 0, ref_cnt)
        end
        att = 1'b0;
        repeat (2) @(negedge clk);
        cnt = 0;
        fork
            P.send(8'h01);
            repeat (12000)
            begin
                @(negedge clk);
                if (st !== 1'b1) cnt++;
            end
        join
        `CHK("detached_ignore", 0, cnt)
        test_done();
    end
endmodule : test_safety_switch_output_logic
